// ===== design/gpio_cmd_handler.sv
// Interprets GPIO data commands of up to 16 bytes from the bulk OUT stream and
// answers on the bulk IN stream. Assumes the USB core delivers one byte per
// valid/ready beat with a last flag, and resets us on USB bus reset.
// Pins of the four ports are seen through pin_in after the port pin data outputs are driven.

// Contract
// RL1: Command 0x00 as first OUT byte queries firmware version.
// RL2: Version answer: 0x01, length 0x05, error, version, checksum.
// RL3: Command 0x02 answers 0x03 with port 0 pin data.
// RL4: Command 0x04 answers 0x05 with port 2 pin data.
// RL5: Command 0x06 answers 0x07 with port 3 pin data.
// RL6: Command 0x08 answers 0x09 with port 4 pin data.
// RL7: Command 0x0A answers 0x0B with ports 4,3,2,0 then checksum.
// RL8: Command 0x10 writes port 0, answers 0x11 with read-back.
// RL9: Command 0x12 writes port 2, answers 0x13 with read-back.
// RL10: Command 0x14 writes port 3, answers 0x15 with read-back.
// RL11: Command 0x16 writes port 4, answers 0x17 with read-back.
// RL12: Command 0x18 writes ports 4,3,2,0 from bytes one to four.
// RL13: Written ports are re-read at once; 0x19 returns four read-backs. The code re-reads only after a READBACK_CYCLES settle wait.
// RL14: Checksum is the negated sum of all earlier response bytes.
// RL15: Length byte counts code through checksum inclusive.
// RL16: Host sends at most 16 bytes per command transfer.
// RL17: Commands arrive on OUT endpoint 2, results leave on IN 1.
// RL18: Error byte zero on success, nonzero otherwise.
module gpio_cmd_handler
  import gpio_cmd_pkg::*;
#(
  parameter logic [7:0] FW_VERSION = VERSION_DEFAULT,
  parameter int READBACK_CYCLES = 2
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Bulk OUT endpoint 2 byte stream
  input wire logic [7:0] out_data,
  input wire logic out_valid,
  input wire logic out_last,
  output logic out_ready,
  // Bulk IN endpoint 1 byte stream
  output logic [7:0] in_data,
  output logic in_valid,
  output logic in_last,
  input wire logic in_ready,
  // GPIO port data
  output logic [7:0] port0_pin_data,
  output logic [7:0] port2_pin_data,
  output logic [7:0] port3_pin_data,
  output logic [7:0] port4_pin_data,
  input wire logic [31:0] pin_in
);

  state_t state_reg, state_next;
  logic [7:0] cmd_reg [OUT_MAX_BYTES];
  logic [IDX_W:0] cnt_reg;
  logic [7:0] port_reg [PORT_COUNT];
  logic [7:0] pin_byte [PORT_COUNT];
  logic [3:0] wait_reg;
  logic [7:0] body [RSP_MAX_BYTES-1];
  logic [IDX_W-1:0] body_len;
  logic framer_busy;
  logic load;
  logic out_take;
  logic [IDX_W:0] got_reg;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire [7:0] code = cmd_reg[OFF_CODE];
  wire is_ver = code == CMD_VERSION; // see RL1
  wire is_rd1 = code == CMD_RD_P0 || code == CMD_RD_P2 ||
                code == CMD_RD_P3 || code == CMD_RD_P4;
  wire is_wr1 = code == CMD_WR_P0 || code == CMD_WR_P2 ||
                code == CMD_WR_P3 || code == CMD_WR_P4;
  wire is_rdall = code == CMD_RD_ALL;
  wire is_wrall = code == CMD_WR_ALL;
  wire known = is_ver || is_rd1 || is_wr1 || is_rdall || is_wrall;
  wire [1:0] sel = code == CMD_RD_P0 || code == CMD_WR_P0 ? 2'(P0) :
                   code == CMD_RD_P2 || code == CMD_WR_P2 ? 2'(P2) :
                   code == CMD_RD_P3 || code == CMD_WR_P3 ? 2'(P3) : 2'(P4);
  // Write commands missing their data bytes are refused, not half done
  // Byte count of the finished command; the live counter is back at zero
  wire too_short = (is_wr1 && got_reg < 5'(OFF_ARG0 + 1)) ||
                   (is_wrall && got_reg < 5'(OFF_ARG3 + 1));
  wire ok = known && !too_short;
  wire [7:0] err = !known ? ERR_BAD_CMD :
                   too_short ? ERR_SHORT_CMD : ERR_NONE; // see RL18
  wire wide = is_rdall || is_wrall;
  wire [7:0] rsp_code = is_ver ? RSP_VERSION :
                        code == CMD_RD_ALL ? RSP_RD_ALL :
                        code == CMD_WR_ALL ? RSP_WR_ALL : // see RL13
                        code == CMD_RD_P0 ? RSP_RD_P0 : // see RL3
                        code == CMD_RD_P2 ? RSP_RD_P2 : // see RL4
                        code == CMD_RD_P3 ? RSP_RD_P3 : // see RL5
                        code == CMD_RD_P4 ? RSP_RD_P4 : // see RL6
                        code == CMD_WR_P0 ? RSP_WR_P0 : // see RL8
                        code == CMD_WR_P2 ? RSP_WR_P2 : // see RL9
                        code == CMD_WR_P3 ? RSP_WR_P3 : // see RL10
                        RSP_WR_P4; // see RL11

  // ----------------------------------------------------------------
  // Pin bytes as seen on the pins
  // ----------------------------------------------------------------
  for (genvar p = 0; p < PORT_COUNT; p++) begin : g_pin
    assign pin_byte[p] = pin_in[p*8 +: 8];
  end

  assign port0_pin_data = port_reg[P0];
  assign port2_pin_data = port_reg[P2];
  assign port3_pin_data = port_reg[P3];
  assign port4_pin_data = port_reg[P4];

  // ----------------------------------------------------------------
  // Response body
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < RSP_MAX_BYTES - 1; i++) begin
      body[i] = 8'h00;
    end
    body[0] = ok ? rsp_code : RSP_INVALID;
    body[2] = err;
    if (!ok) begin
      body[1] = LEN_ERROR;
      body_len = 4'd3;
    end else if (wide) begin
      body[1] = LEN_WIDE; // see RL15
      body[3] = pin_byte[P4]; // see RL7
      body[4] = pin_byte[P3];
      body[5] = pin_byte[P2];
      body[6] = pin_byte[P0];
      body_len = 4'd7;
    end else begin
      body[1] = LEN_SHORT; // see RL15
      body[3] = is_ver ? FW_VERSION : pin_byte[sel]; // see RL2
      body_len = 4'd4;
    end
  end

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  // Commands are taken only while idle and the answer is gone
  assign out_ready = state_reg == ST_IDLE && !framer_busy; // see RL17
  assign out_take = out_valid && out_ready;
  assign load = state_reg == ST_SEND && !framer_busy;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (out_take && out_last) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_next = ST_READBACK;
      end
      ST_READBACK: begin
        // Settle time lets written pins show on pin_in
        if (wait_reg == 4'(READBACK_CYCLES)) begin
          state_next = ST_SEND;
        end
      end
      ST_SEND: begin
        if (!framer_busy) begin
          state_next = ST_IDLE; // see RL17
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      wait_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      wait_reg <= state_reg == ST_READBACK ? wait_reg + 4'h1 : 4'h0;
    end
  end

  // Bytes seventeen to thirty-two are dropped, later ones wrap onto byte one; the host should not send them
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
      for (int i = 0; i < OUT_MAX_BYTES; i++) begin
        cmd_reg[i] <= 8'h00;
      end
    end else if (out_take) begin
      if (cnt_reg < 5'(OUT_MAX_BYTES)) begin // see RL16
        cmd_reg[cnt_reg[3:0]] <= out_data;
      end
      cnt_reg <= out_last ? '0 : cnt_reg + 1'b1;
    end else if (state_reg == ST_IDLE && cnt_reg == '0) begin
      cmd_reg[OFF_CODE] <= cmd_reg[OFF_CODE];
    end
  end

  // Separate counter of received bytes for the finished command
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      got_reg <= '0;
    end else if (out_take && out_last) begin
      got_reg <= cnt_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Port data writes
  // ----------------------------------------------------------------
  wire do_wr = state_reg == ST_EXEC && ok;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < PORT_COUNT; i++) begin
        port_reg[i] <= PORT_RESET;
      end
    end else if (do_wr && is_wr1) begin
      port_reg[sel] <= cmd_reg[OFF_ARG0]; // see RL8
    end else if (do_wr && is_wrall) begin
      port_reg[P4] <= cmd_reg[1]; // see RL12
      port_reg[P3] <= cmd_reg[2];
      port_reg[P2] <= cmd_reg[3];
      port_reg[P0] <= cmd_reg[4];
    end
  end

  rsp_framer u_framer (
    .clk(clk),
    .resetn(resetn),
    .load(load),
    .body(body),
    .body_len(body_len),
    .busy(framer_busy),
    .in_data(in_data),
    .in_valid(in_valid),
    .in_last(in_last),
    .in_ready(in_ready)
  );

endmodule // gpio_cmd_handler

// ===== design/rsp_framer.sv
// Serialises one response packet and appends the checksum of its first body_len bytes.
// Assumes the IN endpoint takes a byte when valid and ready are both high.
module rsp_framer
  import gpio_cmd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Packet load
  input wire logic load,
  input wire logic [7:0] body [RSP_MAX_BYTES-1],
  input wire logic [IDX_W-1:0] body_len,
  output logic busy,
  // IN endpoint stream
  output logic [7:0] in_data,
  output logic in_valid,
  output logic in_last,
  input wire logic in_ready
);

  logic [7:0] buf_reg [RSP_MAX_BYTES];
  logic [IDX_W-1:0] idx_reg;
  logic [IDX_W-1:0] last_idx_reg;
  logic busy_reg;
  logic [7:0] sum_next;
  logic take;

  // ----------------------------------------------------------------
  // Checksum over the body bytes
  // ----------------------------------------------------------------
  always_comb begin
    sum_next = 8'h00;
    for (int i = 0; i < RSP_MAX_BYTES - 1; i++) begin
      if (IDX_W'(i) < body_len) begin
        sum_next = sum_next + body[i];
      end
    end
  end

  assign take = busy_reg && in_ready;
  assign busy = busy_reg;
  assign in_valid = busy_reg;
  assign in_data = buf_reg[idx_reg[2:0]];
  assign in_last = busy_reg && (idx_reg == last_idx_reg);

  // ----------------------------------------------------------------
  // Packet buffer and read pointer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < RSP_MAX_BYTES; i++) begin
        buf_reg[i] <= 8'h00;
      end
      idx_reg <= '0;
      last_idx_reg <= '0;
      busy_reg <= 1'b0;
    end else if (load && !busy_reg) begin
      for (int i = 0; i < RSP_MAX_BYTES - 1; i++) begin
        buf_reg[i] <= body[i];
      end
      // Checksum is the negated sum, placed right after the body
      buf_reg[body_len[2:0]] <= 8'h00 - sum_next; // see RL14
      idx_reg <= '0;
      last_idx_reg <= body_len;
      busy_reg <= 1'b1;
    end else if (take) begin
      if (idx_reg == last_idx_reg) begin
        busy_reg <= 1'b0;
      end
      idx_reg <= idx_reg + 1'b1;
    end
  end

endmodule // rsp_framer

// ===== shared/gpio_cmd_pkg.sv
// Command and response codes, packet layout and limits of the GPIO data
// command handler. Shared by the handler and its byte framer.
package gpio_cmd_pkg;

  localparam int BYTE_W = 8;
  localparam int PORT_COUNT = 4;
  localparam int OUT_MAX_BYTES = 16;
  localparam int RSP_MAX_BYTES = 8;
  localparam int IDX_W = 4;

  // Command codes
  localparam logic [7:0] CMD_VERSION = 8'h00;
  localparam logic [7:0] CMD_RD_P0 = 8'h02;
  localparam logic [7:0] CMD_RD_P2 = 8'h04;
  localparam logic [7:0] CMD_RD_P3 = 8'h06;
  localparam logic [7:0] CMD_RD_P4 = 8'h08;
  localparam logic [7:0] CMD_RD_ALL = 8'h0a;
  localparam logic [7:0] CMD_WR_P0 = 8'h10;
  localparam logic [7:0] CMD_WR_P2 = 8'h12;
  localparam logic [7:0] CMD_WR_P3 = 8'h14;
  localparam logic [7:0] CMD_WR_P4 = 8'h16;
  localparam logic [7:0] CMD_WR_ALL = 8'h18;

  // Response codes
  localparam logic [7:0] RSP_VERSION = 8'h01;
  localparam logic [7:0] RSP_RD_P0 = 8'h03;
  localparam logic [7:0] RSP_RD_P2 = 8'h05;
  localparam logic [7:0] RSP_RD_P3 = 8'h07;
  localparam logic [7:0] RSP_RD_P4 = 8'h09;
  localparam logic [7:0] RSP_RD_ALL = 8'h0b;
  localparam logic [7:0] RSP_WR_P0 = 8'h11;
  localparam logic [7:0] RSP_WR_P2 = 8'h13;
  localparam logic [7:0] RSP_WR_P3 = 8'h15;
  localparam logic [7:0] RSP_WR_P4 = 8'h17;
  localparam logic [7:0] RSP_WR_ALL = 8'h19;
  localparam logic [7:0] RSP_INVALID = 8'hff;

  // Response lengths, code through checksum
  localparam logic [7:0] LEN_SHORT = 8'h05;
  localparam logic [7:0] LEN_WIDE = 8'h08;
  localparam logic [7:0] LEN_ERROR = 8'h04;

  // Error byte values
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_BAD_CMD = 8'h01;
  localparam logic [7:0] ERR_SHORT_CMD = 8'h02;

  // Command byte offsets
  localparam int OFF_CODE = 0;
  localparam int OFF_ARG0 = 1;
  localparam int OFF_ARG3 = 4;

  // Port index inside the 32-bit pin word
  localparam int P0 = 0;
  localparam int P2 = 1;
  localparam int P3 = 2;
  localparam int P4 = 3;

  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [7:0] VERSION_DEFAULT = 8'h10;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_READBACK,
    ST_SEND
  } state_t;

endpackage : gpio_cmd_pkg

// ===== test/gpio_cmd_monitor.sv
// Port checker of the GPIO command handler, bound to its top module.
// Assumes one command, then its whole answer, as the handler enforces.
module gpio_cmd_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Streams
  input wire logic [7:0] out_data,
  input wire logic out_valid,
  input wire logic out_last,
  input wire logic out_ready,
  input wire logic [7:0] in_data,
  input wire logic in_valid,
  input wire logic in_last,
  input wire logic in_ready,
  // Pins
  input wire logic [7:0] port0_pin_data,
  input wire logic [7:0] port2_pin_data,
  input wire logic [7:0] port3_pin_data,
  input wire logic [7:0] port4_pin_data,
  input wire logic [31:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] ob_reg;
  logic [3:0] ib_reg;
  logic [7:0] cmd_reg, arg_reg, sum_reg, len_reg;
  wire out_beat = out_valid && out_ready;
  wire in_beat = in_valid && in_ready;
  wire rd_cmd = cmd_reg <= 8'h0a && !cmd_reg[0];
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {ob_reg, ib_reg, cmd_reg, arg_reg, sum_reg, len_reg} <= '0;
    end else begin
      if (out_beat) ob_reg <= out_last ? 5'h0 : ob_reg + 5'h1;
      if (out_beat && ob_reg == 5'h0) cmd_reg <= out_data;
      if (out_beat && ob_reg == 5'h1) arg_reg <= out_data;
      if (in_beat) ib_reg <= in_last ? 4'h0 : ib_reg + 4'h1;
      if (in_beat) sum_reg <= in_last ? 8'h00 : sum_reg + in_data;
      if (in_beat && ib_reg == 4'h1) len_reg <= in_data;
    end
  end
  AST_HOLD: assert property (in_valid && !in_ready |=>
    in_valid && $stable(in_data)) else $error("in byte dropped");
  AST_REFUSE: assert property (in_valid |-> !out_ready)
    else $error("command taken during answer");
  AST_ANSWER: assert property (out_beat && out_last |-> ##[1:40] in_valid)
    else $error("no answer");
  AST_CODE: assert property (in_valid && ib_reg == 4'h0 && rd_cmd |->
    in_data == cmd_reg + 8'h01) else $error("bad response code");
  AST_LEN: assert property (in_valid && ib_reg == 4'h1 && rd_cmd |->
    in_data == (cmd_reg == 8'h0a ? 8'h08 : 8'h05)) else $error("bad length");
  AST_ERR: assert property (in_valid && ib_reg == 4'h2 && rd_cmd |->
    in_data == 8'h00) else $error("error byte set");
  AST_CKSUM: assert property (in_beat && in_last |->
    sum_reg + in_data == 8'h00) else $error("bad checksum");
  AST_COUNT: assert property (in_beat && in_last |->
    {4'h0, ib_reg} + 8'h01 == len_reg) else $error("length mismatch");
  AST_WR0: assert property (in_valid && ib_reg == 4'h3 &&
    len_reg == 8'h05 && cmd_reg == 8'h10 |-> port0_pin_data == arg_reg)
    else $error("port 0 not written");
  AST_RD0: assert property (in_valid && ib_reg == 4'h3 &&
    cmd_reg == 8'h02 |-> in_data == pin_in[7:0]) else $error("bad pins");
  cover property (in_beat && in_last && cmd_reg == 8'h18);
  cover property (in_valid && !in_ready);
  cover property (in_beat && ib_reg == 4'h0 && in_data == 8'hff);
endmodule // gpio_cmd_monitor

bind gpio_cmd_handler gpio_cmd_monitor gpio_cmd_monitor_inst (.clk, .resetn,
  .out_data, .out_valid, .out_last, .out_ready, .in_data, .in_valid, .in_last,
  .in_ready, .port0_pin_data, .port2_pin_data, .port3_pin_data,
  .port4_pin_data, .pin_in);

// ===== test/gpio_pin_model.sv
// Pin model: each pin echoes its driven port value, optionally flipped.
// Assumes the bench changes flip only between commands.
module gpio_pin_model (
  // Driven port values
  input wire logic [7:0] port0_pin_data,
  input wire logic [7:0] port2_pin_data,
  input wire logic [7:0] port3_pin_data,
  input wire logic [7:0] port4_pin_data,
  // Injected pin disagreement
  input wire logic [31:0] flip,
  // Pins seen by the handler
  output logic [31:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Flip makes read-back differ from the written value
  assign pin_in = {port4_pin_data, port3_pin_data, port2_pin_data,
                   port0_pin_data} ^ flip;
endmodule // gpio_pin_model

// ===== test/tb_usb_gpio_data_command_handler.sv
// Self-checking bench: sends every command, compares each answer byte
// and the port drive values with a queue model. Pins echo the ports, flipped by a random mask on the second pass.
module tb_usb_gpio_data_command_handler;
  import gpio_cmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef logic [7:0] bq_t[$];
  logic clk, resetn, out_valid, out_last, out_ready, in_valid, in_last;
  logic in_ready;
  logic [7:0] out_data, in_data;
  logic [7:0] port0_pin_data, port2_pin_data, port3_pin_data, port4_pin_data;
  logic [31:0] pin_in, flip;
  logic [7:0] pm [4];
  logic [7:0] codes [11] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0a,
    8'h10, 8'h12, 8'h14, 8'h16, 8'h18};
  int errors, compares, seed;
  bq_t c;

  gpio_cmd_handler gpio_cmd_handler_inst (.clk, .resetn, .out_data,
    .out_valid, .out_last, .out_ready, .in_data, .in_valid, .in_last,
    .in_ready, .port0_pin_data, .port2_pin_data, .port3_pin_data,
    .port4_pin_data, .pin_in);
  gpio_pin_model gpio_pin_model_inst (.port0_pin_data, .port2_pin_data,
    .port3_pin_data, .port4_pin_data, .flip, .pin_in);

  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  function automatic logic [7:0] pin(int i);
    return pm[i] ^ flip[8*i +: 8];
  endfunction

  function automatic bq_t model(bq_t c);
    bq_t r;
    int k, s, w;
    k = c[0];
    w = (k - 16) / 2;
    r = {};
    if (k == 0) r = {VERSION_DEFAULT};
    else if (k inside {2, 4, 6, 8}) r = {pin(k / 2 - 1)};
    else if (k == 10) r = {pin(3), pin(2), pin(1), pin(0)};
    else if (k inside {16, 18, 20, 22} && c.size() > 1) begin
      pm[w] = c[1];
      r = {pin(w)};
    end else if (k == 24 && c.size() > 4) begin
      for (int i = 0; i < 4; i++) pm[3 - i] = c[i + 1];
      r = {pin(3), pin(2), pin(1), pin(0)};
    end
    if (r.size() > 0) r = {8'(k + 1), 8'(r.size() + 4), 8'h00, r};
    else r = {8'hff, 8'h04, k inside {16, 18, 20, 22, 24} ? 8'h02 : 8'h01};
    s = 0;
    foreach (r[i]) s += r[i];
    r.push_back(8'(-s));
    return r;
  endfunction

  // ----------------------------------------
  // Stream tasks
  // ----------------------------------------
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h got %h", what, exp, got);
    end
  endtask

  task automatic run(bq_t c);
    bq_t e, g;
    int i, n;
    logic rdy, lst;
    logic [7:0] b;
    e = model(c);
    i = 0;
    n = 0;
    while (i < c.size() && n < 200) begin
      @(negedge clk);
      out_valid = 1;
      out_data = c[i];
      out_last = (i == c.size() - 1);
      // Outputs move only on the rising edge; read them clear of it
      rdy = out_ready;
      @(posedge clk);
      if (rdy === 1'b1) i++;
      n++;
    end
    @(negedge clk);
    out_valid = 0;
    out_last = 0;
    g = {};
    while (n < 600 && (g.size() == 0 || g.size() < e.size())) begin
      @(negedge clk);
      in_ready = 1'($random(seed));
      rdy = in_valid === 1'b1 && in_ready;
      b = in_data;
      lst = in_last;
      @(posedge clk);
      n++;
      if (rdy) begin
        check("in_last", 8'(g.size() == e.size() - 1), 8'(lst));
        g.push_back(b);
      end
    end
    @(negedge clk);
    in_ready = 0;
    check("rsp_size", 8'(e.size()), 8'(g.size()));
    foreach (e[j]) check("rsp_byte", e[j], g[j]);
    check("port0", pm[0], port0_pin_data);
    check("port2", pm[1], port2_pin_data);
    check("port3", pm[2], port3_pin_data);
    check("port4", pm[3], port4_pin_data);
  endtask

  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #500000;
    errors++;
    final_report;
  end

  initial begin
    seed = 21918;
    {out_valid, out_last, in_ready, out_data, flip} = '0;
    pm = '{default: 8'h00};
    resetn = 0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    resetn = 1;
    for (int p = 0; p < 2; p++) begin
      flip = p ? 32'($random(seed)) : 32'h0;
      foreach (codes[i]) begin
        c = {codes[i]};
        repeat (4) c.push_back(8'($random(seed)));
        run(c);
      end
    end
    c = {8'h20};
    run(c);
    c = {8'h10};
    run(c);
    c = {8'h18, 8'h01, 8'h02};
    run(c);
    final_report;
  end
endmodule // tb_usb_gpio_data_command_handler
